// file: bench/ldd_host_model.sv
// Host bus model writing control words and digit data
module ldd_host_model (
  // Bus
  input  wire logic       clock,
  output logic            write_strobe,
  output logic            reg_select,
  output logic      [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    write_strobe = 1'b0;
    reg_select   = 1'b0;
    data_in      = 8'h00;
  end
  // Strobe one cycle, then low; released bus shows inverse data
  task automatic put(input logic sel, input logic [7:0] d);
    @(posedge clock);
    reg_select   <= sel;
    data_in      <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    data_in      <= ~d;
    @(posedge clock);
  endtask : put
endmodule : ldd_host_model

// file: bench/ldd_write_port_sva.sv
// Assertion checker for the LED display write port
module ldd_write_port_sva #(
  parameter bit DIRECT_VARIANT = 1'b0,
  parameter int SCAN_DIV       = 1024
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // Host bus
  input wire logic       write_strobe,
  input wire logic       reg_select,
  input wire logic [7:0] data_in,
  // Display drives
  input wire logic [6:0] segment_drive,
  input wire logic       decimal_point_drive,
  input wire logic [7:0] digit_drive,
  input wire logic       display_on,
  // Direct variant function pin
  input wire logic [1:0] three_level_function_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_r;
  logic tk;
  logic cw;
  always_ff @(posedge clock) begin
    strobe_r <= write_strobe;
  end
  // Taken write and taken control word
  assign tk = write_strobe && !strobe_r;
  assign cw = tk && reg_select && !DIRECT_VARIANT;
  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);
  a_digit_one_hot: assert property ($onehot0(digit_drive))
    else $error("more than one digit driven");
  a_seq_blanks: assert property (cw && data_in[7] |-> ##2 !display_on)
    else $error("display not blanked by sequence word");
  a_power_off: assert property (cw && !data_in[7] && !data_in[4] |-> ##2 !display_on)
    else $error("display not shut down");
  a_power_on: assert property (cw && !data_in[7] && data_in[4] |-> ##2 display_on)
    else $error("display not running");
  a_blank_dark: assert property (!display_on |-> digit_drive == 8'h00
    && segment_drive == 7'h00 && !decimal_point_drive)
    else $error("drives active while display off");
  a_on_cause: assert property ($rose(display_on) |-> $past(srst, 3) || $past(srst, 2)
    || $past(srst) || $past(tk, 2))
    else $error("display turned on without a write");
  a_data_keeps: assert property (tk && !reg_select && display_on |-> ##2 display_on)
    else $error("data write turned display off");
  a_off_cause: assert property ($fell(display_on) |->
    (!DIRECT_VARIANT && $past(cw, 2))
    || (DIRECT_VARIANT && $past(three_level_function_pin) == ldd_pkg::TRI_LOW))
    else $error("display off without control word or shutdown pin");
  c_seq: cover property (cw && data_in[7]);
  c_off: cover property (cw && !data_in[4]);
  c_last: cover property (digit_drive[7]);
  c_raw: cover property (cw && data_in[7] && data_in[5]);
endmodule : ldd_write_port_sva

bind ldd_write_port ldd_write_port_sva #(.DIRECT_VARIANT(DIRECT_VARIANT), .SCAN_DIV(SCAN_DIV))
  chk_u (.clock, .srst, .write_strobe, .reg_select, .data_in, .segment_drive,
  .decimal_point_drive, .digit_drive, .display_on, .three_level_function_pin);

// file: bench/led_display_host_write_port_test.sv
// Self-checking bench for the LED display write port
module led_display_host_write_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        srst  = 1'b1;
  logic        write_strobe, reg_select, display_on, decimal_point_drive;
  logic [7:0]  data_in, digit_drive;
  logic [6:0]  segment_drive;
  logic        d_dp, d_on;
  logic [7:0]  d_digit;
  logic [6:0]  d_seg;
  logic [2:0]  digit_sel = 3'h0;
  logic [1:0]  tri_pin   = ldd_pkg::TRI_HIGH;
  logic [15:0] lfsr      = 16'h000E;
  logic [3:0]  code_a [8];
  logic [3:0]  code_b [8];
  logic        dp [8];
  logic [7:0]  raw_w [8];
  int          n_errors  = 0;
  int          checked   = 0;
  initial begin
    forever #2 clock = ~clock;
  end
  ldd_host_model host_u (.clock, .write_strobe, .reg_select, .data_in);
  ldd_write_port #(.SCAN_DIV(4)) dut_u (.clock, .srst, .write_strobe, .reg_select,
    .data_in, .digit_sel, .three_level_function_pin(tri_pin), .segment_drive,
    .decimal_point_drive, .digit_drive, .display_on);
  // Direct variant shares the host bus; it ignores the select line
  ldd_write_port #(.DIRECT_VARIANT(1'b1), .SCAN_DIV(4)) dut_direct_u (.clock, .srst,
    .write_strobe, .reg_select, .data_in, .digit_sel, .three_level_function_pin(tri_pin),
    .segment_drive(d_seg), .decimal_point_drive(d_dp), .digit_drive(d_digit),
    .display_on(d_on));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : nxt
  function automatic logic [3:0] cd(input logic [15:0] r);
    return (r[1:0] == 2'h0) ? 4'h0 : (r[1:0] == 2'h1) ? 4'h1 : (r[1:0] == 2'h2) ? 4'h8 : 4'hA;
  endfunction : cd
  // Code A reads as a letter in hexadecimal and as a dash in Code B
  function automatic logic [6:0] seg_of(input logic [3:0] c, input bit hex);
    return (c == 4'h0) ? 7'h3F : (c == 4'h1) ? 7'h06 : (c == 4'h8) ? 7'h7F
      : hex ? 7'h77 : 7'h40;
  endfunction : seg_of
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // Walk all eight digits and compare each against the bench's copy
  task automatic scan(input bit direct, input bit bank_a, input bit hex, input bit raw);
    int         w;
    logic [7:0] dig;
    logic [6:0] exp_seg;
    repeat (2) @(negedge clock);
    for (int k = 0; k < 8; k++) begin
      w = 0;
      dig = direct ? d_digit : digit_drive;
      while (dig !== 8'h01 << k && w < 200) begin
        @(negedge clock);
        w++;
        dig = direct ? d_digit : digit_drive;
      end
      if (dig !== 8'h01 << k) begin
        n_errors++;
        results();
      end
      exp_seg = raw ? raw_w[k][6:0] : seg_of(bank_a ? code_a[k] : code_b[k], hex);
      chk(8'(direct ? d_seg : segment_drive), 8'(exp_seg));
      chk(8'(direct ? d_dp : decimal_point_drive), 8'(dp[k]));
    end
  endtask : scan
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] r;
    logic [2:0]  a;
    logic [2:0]  x;
    bit          h;
    bit          bk;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      code_a[k] = 4'h0;
      code_b[k] = 4'h0;
      dp[k]     = 1'b0;
    end
    scan(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) begin
      r = nxt();
      h = r[3];
      host_u.put(1'b1, {1'b1, h, 6'h18});
      for (int k = 0; k < 8; k++) begin
        r = nxt();
        code_a[k] = cd(r);
        dp[k]     = r[7];
        host_u.put(1'b0, {r[7], r[6:4], code_a[k]});
        @(negedge clock);
        chk(8'(display_on), (k < 7) ? 8'h00 : 8'h01);
      end
      host_u.put(1'b0, 8'h88);
      scan(1'b0, 1'b1, h, 1'b0);
      r = nxt();
      a = r[6:4];
      h = r[3];
      bk = r[2];
      host_u.put(1'b1, {1'b0, h, 2'b01, bk, a});
      r = nxt();
      if (bk) begin
        code_a[a] = cd(r);
      end else begin
        code_b[a] = cd(r);
      end
      dp[a] = r[7];
      host_u.put(1'b0, {r[7], r[6:4], cd(r)});
      host_u.put(1'b0, 8'h01);
      scan(1'b0, bk, h, 1'b0);
      host_u.put(1'b1, 8'h10);
      scan(1'b0, 1'b0, 1'b0, 1'b0);
      host_u.put(1'b1, 8'h08);
      repeat (2) @(negedge clock);
      chk({display_on, digit_drive[6:0]}, 8'h00);
      host_u.put(1'b1, 8'h18);
      scan(1'b0, 1'b1, 1'b0, 1'b0);
      // Raw segment fill with bank B selected still lands in the full word
      host_u.put(1'b1, 8'hB0);
      for (int k = 0; k < 8; k++) begin
        r = nxt();
        raw_w[k] = r[7:0];
        dp[k]    = r[7];
        host_u.put(1'b0, r[7:0]);
      end
      scan(1'b0, 1'b0, 1'b0, 1'b1);
    end
    // Direct variant: every digit once, in a shuffled address order
    r = nxt();
    x = r[2:0];
    @(posedge clock);
    for (int k = 0; k < 8; k++) begin
      a = 3'(k) ^ x;
      r = nxt();
      code_a[a] = (k == 0) ? 4'hA : cd(r);
      dp[a]     = ~r[7];
      digit_sel <= a;
      host_u.put(1'b0, {r[7], r[6:4], code_a[a]});
    end
    scan(1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    tri_pin <= ldd_pkg::TRI_FLOAT;
    scan(1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge clock);
    tri_pin <= ldd_pkg::TRI_LOW;
    repeat (2) @(negedge clock);
    chk({d_on, d_digit[6:0]}, 8'h00);
    results();
  end
endmodule : led_display_host_write_port_test

// file: rtl/ldd_pkg.sv
// Constants shared by the LED display host write port
// What this block does
// - Control-select variant latches data into control word or RAM on write rising edge.
// - Select high loads control word, select low loads display RAM.
// - Control bit 4 high runs normally; low blanks display while the scan divider keeps counting.
// - RAM writes store data lines 0 to 3 as stored bits 0 to 3.
// - Control write with sequence flag low takes lines 0 to 2 as digit address.
// - In decode modes, control bit 3 picks bank A when high, bank B low.
// - Direct variant has no control word; writes go straight to addressed RAM.
// - Three-level pin: high hex, float Code B, low shuts down.
// - Direct variant digit address from three address inputs, input 0 least significant.
// - Direct variant decimal point input is active low; low lights the point.
// - Separate drives for segments a to g, decimal point and eight digits.
// - Control bit 7 sets sequence flag; in data writes it is the decimal point.
// - Control bit 5 high selects raw segment mode, low selects decoded display.
// - Control bit 6 high selects hexadecimal, low selects Code B decoding.
// - Sequence flag blanks display, takes eight writes to digits 1..8, then ignores writes.
package ldd_pkg;

  localparam int DIGITS      = 8;
  localparam int ADDR_W      = 3;
  localparam int WORD_W      = 8;
  // Control word fields
  localparam int CTL_BANK    = 3;
  localparam int CTL_RUN     = 4;
  localparam int CTL_RAW     = 5;
  localparam int CTL_HEX     = 6;
  localparam int CTL_SEQ     = 7;
  localparam logic [7:0] CTL_RESET = 8'h10;
  // Decimal point bit in a stored word
  localparam int DP_BIT      = 7;
  // Scan divider: digit period in clock cycles
  localparam int SCAN_DIV    = 1024;
  // Three-level pin codes
  localparam logic [1:0] TRI_LOW   = 2'h0;
  localparam logic [1:0] TRI_FLOAT = 2'h1;
  localparam logic [1:0] TRI_HIGH  = 2'h2;

  typedef enum logic [1:0] {
    LDD_IDLE = 2'b01,
    LDD_SEQ  = 2'b10
  } ldd_state_type;

endpackage : ldd_pkg

// file: rtl/ldd_seg_decode.sv
// Character decoder from 4-bit code to segments a..g
module ldd_seg_decode (
  // Code in
  input  wire logic [3:0] code,
  input  wire logic       hex_mode,
  // Segments out, bit 0 is a
  output logic      [6:0] segs
);

  always_comb begin
    unique case (code)
      4'h0: segs = 7'h3F;
      4'h1: segs = 7'h06;
      4'h2: segs = 7'h5B;
      4'h3: segs = 7'h4F;
      4'h4: segs = 7'h66;
      4'h5: segs = 7'h6D;
      4'h6: segs = 7'h7D;
      4'h7: segs = 7'h07;
      4'h8: segs = 7'h7F;
      4'h9: segs = 7'h6F;
      4'hA: segs = hex_mode ? 7'h77 : 7'h40;
      4'hB: segs = hex_mode ? 7'h7C : 7'h79;
      4'hC: segs = hex_mode ? 7'h39 : 7'h76;
      4'hD: segs = hex_mode ? 7'h5E : 7'h38;
      4'hE: segs = hex_mode ? 7'h79 : 7'h73;
      4'hF: segs = hex_mode ? 7'h71 : 7'h00;
    endcase
  end

endmodule : ldd_seg_decode

// file: rtl/ldd_write_port.sv
// Host write port, display RAM and scan for the 8-digit LED driver
module ldd_write_port #(
  parameter bit DIRECT_VARIANT = 1'b0,
  parameter int SCAN_DIV       = ldd_pkg::SCAN_DIV
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Host bus
  input  wire logic       write_strobe,
  input  wire logic       reg_select,
  input  wire logic [7:0] data_in,
  // Direct variant inputs
  input  wire logic [2:0] digit_sel,
  input  wire logic [1:0] three_level_function_pin,
  // Display drives
  output logic      [6:0] segment_drive,
  output logic            decimal_point_drive,
  output logic      [7:0] digit_drive,
  // Status
  output logic            display_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe edge
  logic       strobe_d_r;
  logic       strobe_d_nxt;
  logic       wr_rise;

  always_comb begin
    strobe_d_nxt = write_strobe;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe_d_nxt;
    end
  end

  assign wr_rise = write_strobe & ~strobe_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control word and sequence state
  logic [7:0]                 ctl_r;
  logic [7:0]                 ctl_nxt;
  ldd_pkg::ldd_state_type     state_r;
  ldd_pkg::ldd_state_type     state_nxt;
  logic [2:0]                 addr_r;
  logic [2:0]                 addr_nxt;
  logic                       single_pend_r;
  logic                       single_pend_nxt;
  logic                       ram_we;
  logic [2:0]                 ram_addr;
  logic [7:0]                 ram_word;
  logic                       bank_wr;
  logic                       decoded;

  assign decoded = ~ctl_r[ldd_pkg::CTL_RAW];

  always_comb begin
    ctl_nxt         = ctl_r;
    state_nxt       = state_r;
    addr_nxt        = addr_r;
    single_pend_nxt = single_pend_r;
    ram_we          = 1'b0;
    ram_addr        = addr_r;
    ram_word        = data_in;
    bank_wr         = ctl_r[ldd_pkg::CTL_BANK];
    if (DIRECT_VARIANT) begin
      if (wr_rise) begin
        ram_we   = 1'b1;
        ram_addr = digit_sel;
        // Code in bits 0..3, decimal point active low
        ram_word = {~data_in[7], 3'h0, data_in[3:0]};
        bank_wr  = 1'b1;
      end
    end else if (wr_rise) begin
      if (reg_select) begin
        ctl_nxt = data_in;
        if (data_in[ldd_pkg::CTL_SEQ]) begin
          state_nxt       = ldd_pkg::LDD_SEQ;
          addr_nxt        = 3'h0;
          single_pend_nxt = 1'b0;
        end else begin
          state_nxt       = ldd_pkg::LDD_IDLE;
          addr_nxt        = data_in[2:0];
          single_pend_nxt = 1'b1;
        end
      end else begin
        // Bits 0..3 stored in order; bit 7 is the decimal point
        ram_word = data_in;
        unique case (state_r)
          ldd_pkg::LDD_SEQ: begin
            ram_we   = 1'b1;
            addr_nxt = addr_r + 3'h1;
            if (addr_r == 3'h7) begin
              state_nxt = ldd_pkg::LDD_IDLE;
            end
          end
          ldd_pkg::LDD_IDLE: begin
            ram_we          = single_pend_r;
            single_pend_nxt = 1'b0;
          end
          default: begin
            state_nxt = ldd_pkg::LDD_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctl_r         <= ldd_pkg::CTL_RESET;
      state_r       <= ldd_pkg::LDD_IDLE;
      addr_r        <= 3'h0;
      single_pend_r <= 1'b0;
    end else begin
      ctl_r         <= ctl_nxt;
      state_r       <= state_nxt;
      addr_r        <= addr_nxt;
      single_pend_r <= single_pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display RAM: two banks of 4-bit codes, one raw/dp word per digit
  logic [7:0] raw_mem [ldd_pkg::DIGITS];
  logic [3:0] bank_b  [ldd_pkg::DIGITS];

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < ldd_pkg::DIGITS; i++) begin
        raw_mem[i] <= 8'h00;
        bank_b[i]  <= 4'h0;
      end
    end else if (ram_we) begin
      // Decimal point shared by both banks; decoded code goes to chosen bank
      if (!decoded || bank_wr) begin
        raw_mem[ram_addr] <= ram_word;
      end else begin
        raw_mem[ram_addr][ldd_pkg::DP_BIT] <= ram_word[ldd_pkg::DP_BIT];
        bank_b[ram_addr] <= ram_word[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic run;
  logic hex_mode;
  logic raw_mode;
  logic bank_a_disp;

  always_comb begin
    if (DIRECT_VARIANT) begin
      run         = (three_level_function_pin != ldd_pkg::TRI_LOW);
      hex_mode    = (three_level_function_pin == ldd_pkg::TRI_HIGH);
      raw_mode    = 1'b0;
      bank_a_disp = 1'b1;
    end else begin
      run         = ctl_r[ldd_pkg::CTL_RUN];
      hex_mode    = ctl_r[ldd_pkg::CTL_HEX];
      raw_mode    = ctl_r[ldd_pkg::CTL_RAW];
      bank_a_disp = ctl_r[ldd_pkg::CTL_BANK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan divider and digit pointer
  logic [$clog2(SCAN_DIV)-1:0] div_r;
  logic [$clog2(SCAN_DIV)-1:0] div_nxt;
  logic [2:0]                  scan_r;
  logic [2:0]                  scan_nxt;

  always_comb begin
    div_nxt  = div_r + 1'b1;
    scan_nxt = scan_r;
    if (div_r == ($clog2(SCAN_DIV))'(SCAN_DIV - 1)) begin
      div_nxt  = '0;
      scan_nxt = scan_r + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      div_r  <= '0;
      scan_r <= 3'h0;
    end else begin
      div_r  <= div_nxt;
      scan_r <= scan_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drives
  logic [7:0] cur_word;
  logic [3:0] cur_code;
  logic [6:0] dec_segs;
  logic [6:0] seg_nxt;
  logic       dp_nxt;
  logic [7:0] dig_nxt;
  logic       on_nxt;

  assign cur_word = raw_mem[scan_r];
  assign cur_code = bank_a_disp ? cur_word[3:0] : bank_b[scan_r];

  ldd_seg_decode u_dec (
    .code     (cur_code),
    .hex_mode (hex_mode),
    .segs     (dec_segs)
  );

  always_comb begin
    // Blank while shut down or during a sequential load
    on_nxt  = run && (DIRECT_VARIANT || state_r != ldd_pkg::LDD_SEQ);
    seg_nxt = raw_mode ? cur_word[6:0] : dec_segs;
    dp_nxt  = cur_word[ldd_pkg::DP_BIT];
    dig_nxt = 8'h01 << scan_r;
    if (!on_nxt) begin
      seg_nxt = 7'h00;
      dp_nxt  = 1'b0;
      dig_nxt = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      segment_drive       <= 7'h00;
      decimal_point_drive <= 1'b0;
      digit_drive         <= 8'h00;
      display_on          <= 1'b0;
    end else begin
      segment_drive       <= seg_nxt;
      decimal_point_drive <= dp_nxt;
      digit_drive         <= dig_nxt;
      display_on          <= on_nxt;
    end
  end

endmodule : ldd_write_port
